/* verilog/ifb_pkg.sv */
`default_nettype none
// ----------------------------------------------------------------------
// Shared constants and carriers of the bar and change-flag block
// ----------------------------------------------------------------------
package ifb_pkg;

	// ------------------------------------------------------------------
	// Register addresses on the control port
	// ------------------------------------------------------------------
	localparam logic [7:0] IFB_ADDR_PIXEL_REP       = 8'h85;
	localparam logic [7:0] IFB_ADDR_TOP_END_LO      = 8'h86;
	localparam logic [7:0] IFB_ADDR_CHANGE_FLAGS    = 8'h87;
	localparam logic [7:0] IFB_ADDR_TOP_END_HI      = 8'h88;
	localparam logic [7:0] IFB_ADDR_BOTTOM_START_LO = 8'h89;
	localparam logic [7:0] IFB_ADDR_BOTTOM_START_HI = 8'h8a;
	localparam logic [7:0] IFB_ADDR_LEFT_END_LO     = 8'h8b;
	localparam logic [7:0] IFB_ADDR_LEFT_END_HI     = 8'h8c;
	localparam logic [7:0] IFB_ADDR_RIGHT_START_LO  = 8'h8d;
	localparam logic [7:0] IFB_ADDR_RIGHT_START_HI  = 8'h8e;
	localparam logic [7:0] IFB_ADDR_CHANGE_MIRROR   = 8'h8f;

	// ------------------------------------------------------------------
	// Field layouts, widths and reset values
	// ------------------------------------------------------------------
	localparam int         IFB_PKT_TYPES   = 7;
	localparam int         IFB_SIG_W       = 32;
	localparam int         IFB_BARS        = 4;
	localparam logic [3:0] IFB_PR_FIRST_RSV = 4'ha;
	localparam logic [3:0] IFB_PR_PAD      = 4'h0;
	localparam logic [0:0] IFB_FLAG_PAD    = 1'h0;
	localparam logic [7:0] IFB_UNMAPPED    = 8'h00;
	localparam logic [6:0] IFB_FLAGS_RST   = 7'h00;
	localparam logic [15:0] IFB_BAR_NONE   = 16'h0000;

	// Bar index within the bar array
	localparam int IFB_BAR_TOP    = 0;
	localparam int IFB_BAR_BOTTOM = 1;
	localparam int IFB_BAR_LEFT   = 2;
	localparam int IFB_BAR_RIGHT  = 3;

	// Change flag bit positions
	localparam int IFB_PKT_AVI   = 0;
	localparam int IFB_PKT_AUDIO = 1;
	localparam int IFB_PKT_SPD   = 2;
	localparam int IFB_PKT_MPEG  = 3;
	localparam int IFB_PKT_ACP   = 4;
	localparam int IFB_PKT_ISRC1 = 5;
	localparam int IFB_PKT_ISRC2 = 6;

	// ------------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------------
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ifb_reg_req_s;

	typedef struct packed {
		logic [3:0]                      pixel_repetition_code;
		logic [IFB_BARS-1:0][15:0]       bar;
	} ifb_avi_s;

	typedef struct packed {
		logic                 valid;
		logic [2:0]           idx;
		logic [IFB_SIG_W-1:0] sig;
	} ifb_pkt_s;

	typedef struct packed {
		logic no_top;
		logic no_bottom;
		logic no_left;
		logic no_right;
		logic pr_reserved;
	} ifb_bar_status_s;

	typedef struct packed {
		logic [IFB_PKT_TYPES-1:0][IFB_SIG_W-1:0] words;
		logic [IFB_SIG_W-1:0]                    rdata;
	} ifb_sig_mem_s;

endpackage
`default_nettype wire

/* verilog/ifb_sig_mem.sv */
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------------
// Last-seen content signature, one word per packet type
// ----------------------------------------------------------------------
module ifb_sig_mem (
	// Clock and reset
	input  wire logic                          mclk,
	input  wire logic                          nrst,
	// Read side, data one cycle later
	input  wire logic                          rd_en,
	input  wire logic [2:0]                    rd_idx,
	output logic [ifb_pkg::IFB_SIG_W-1:0]      rd_data,
	// Write side
	input  wire logic                          wr_en,
	input  wire logic [2:0]                    wr_idx,
	input  wire logic [ifb_pkg::IFB_SIG_W-1:0] wr_data
);

	ifb_pkg::ifb_sig_mem_s cur;
	ifb_pkg::ifb_sig_mem_s next_cur;

	// Registered read; caller keeps indices below the type count
	always_comb begin
		next_cur = cur;
		if (rd_en) begin
			next_cur.rdata = cur.words[rd_idx];
		end
		if (wr_en) begin
			next_cur.words[wr_idx] = wr_data;
		end
	end

	// State register
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign rd_data = cur.rdata;

endmodule // ifb_sig_mem
`default_nettype wire

/* verilog/ifb_regs.sv */
// Functional notes
// R1: Read-only 4-bit field at 0x85 reports the received pixel repetition.
// R2: Repetition code means transmissions minus one; code 1001 means ten sends.
// R3: Software treats codes 0xA to 0xF as reserved, not as counts.
// R4: Top bar end line is 16 bits, low byte 0x86, high 0x88.
// R5: Top bar end line of zero means no top bar.
// R6: Lower bar start line is 16 bits, low byte 0x89, high 0x8A.
// R7: Lower bar start beyond active line count means no lower bar.
// R8: Left bar end pixel is 16 bits, low byte 0x8B, high 0x8C.
// R9: Left bar end pixel of zero means no left bar.
// R10: Right bar start pixel is 16 bits, low byte 0x8D, high 0x8E.
// R11: Right bar start beyond maximum pixel count means no right bar.
// R12: Bar registers are read-only bytes; writes change nothing.
// R13: Seven change flags, each set when its packet type contents change.
// R14: With no changes the flag set reads all zeros.
// R15: Reading a flag register returns flags, then clears all seven.
// R16: Flag addresses 0x87 and 0x8F mirror one shared flag set.
// R17: Flag bits: AVI, audio, SPD, MPEG, ACP, ISRC1, ISRC2 from bit 0.
// R18: A change in the same cycle as a clearing read stays set.
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------------
// Bar limits, repetition code and packet change flags
// ----------------------------------------------------------------------
module ifb_regs (
	// Clock and reset
	input  wire logic                     mclk,
	input  wire logic                     nrst,
	// Register port
	input  wire ifb_pkg::ifb_reg_req_s    reg_req,
	output logic [7:0]                    reg_rdata,
	output logic                          reg_rvalid,
	// Decoded auxiliary video information
	input  wire logic                     avi_upd,
	input  wire ifb_pkg::ifb_avi_s        avi_in,
	// Received packet events with content signature
	input  wire ifb_pkg::ifb_pkt_s        pkt_in,
	// Picture size for bar presence checks
	input  wire logic [15:0]              active_lines,
	input  wire logic [15:0]              max_pixels,
	// Decoded status
	output ifb_pkg::ifb_bar_status_s      bar_status,
	output logic [ifb_pkg::IFB_PKT_TYPES-1:0] change_flags
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		ifb_pkg::ifb_avi_s                         avi;
		logic [ifb_pkg::IFB_BARS-1:0][7:0]         hold_hi;
		logic [ifb_pkg::IFB_BARS-1:0]              hold_vld;
		logic [ifb_pkg::IFB_PKT_TYPES-1:0]         flags;
		logic [ifb_pkg::IFB_PKT_TYPES-1:0]         seen;
		logic                                      s1_valid;
		logic [2:0]                                s1_idx;
		logic [ifb_pkg::IFB_SIG_W-1:0]             s1_sig;
		logic                                      s1_fwd;
		logic [ifb_pkg::IFB_SIG_W-1:0]             s1_fwd_sig;
		logic [7:0]                                rdata;
		logic                                      rvalid;
		ifb_pkg::ifb_bar_status_s                  status;
	} ifb_regs_state_s;

	ifb_regs_state_s cur;
	ifb_regs_state_s next_cur;

	// ------------------------------------------------------------------
	// Signature memory and change detection
	// ------------------------------------------------------------------
	logic                                 pkt_ok;
	logic [ifb_pkg::IFB_SIG_W-1:0]        mem_rdata;
	logic [ifb_pkg::IFB_SIG_W-1:0]        prev_sig;
	logic                                 s1_changed;
	logic [ifb_pkg::IFB_PKT_TYPES-1:0]    change_hit;

	// Types beyond the flag count are dropped, never index the memory
	assign pkt_ok = pkt_in.valid && (pkt_in.idx < 3'(ifb_pkg::IFB_PKT_TYPES));

	ifb_sig_mem i_ifb_sig_mem (
		.mclk    (mclk),
		.nrst    (nrst),
		.rd_en   (pkt_ok),
		.rd_idx  (pkt_in.idx),
		.rd_data (mem_rdata),
		.wr_en   (cur.s1_valid),
		.wr_idx  (cur.s1_idx),
		.wr_data (cur.s1_sig)
	);

	// Forwarding covers two packets of one type on back-to-back cycles,
	// where the memory still holds the older word
	assign prev_sig   = cur.s1_fwd ? cur.s1_fwd_sig : mem_rdata;
	// First packet of a type counts as a change from nothing
	assign s1_changed = !cur.seen[cur.s1_idx] || (prev_sig != cur.s1_sig); // R13

	// One hit line per flag bit, bit order follows packet type index
	genvar gi;
	generate
		for (gi = 0; gi < ifb_pkg::IFB_PKT_TYPES; gi++) begin : g_hit
			assign change_hit[gi] = cur.s1_valid && (cur.s1_idx == 3'(gi)) &&
			                        s1_changed; // R17
		end
	endgenerate

	// ------------------------------------------------------------------
	// Register decode
	// ------------------------------------------------------------------
	logic [7:0]                     rd_byte;
	logic                           flag_rd;
	logic [ifb_pkg::IFB_BARS-1:0]   lo_rd;
	logic [ifb_pkg::IFB_BARS-1:0]   hi_rd;

	// High byte comes from the snapshot taken at the low byte read,
	// so a bar update between the two reads cannot tear the value
	function automatic logic [7:0] hi_byte(input ifb_regs_state_s s, input int b);
		logic [7:0] v;
		v = s.hold_vld[b] ? s.hold_hi[b] : s.avi.bar[b][15:8];
		return v;
	endfunction

	// Read mux; writes are never decoded, bars are read-only
	always_comb begin
		rd_byte = ifb_pkg::IFB_UNMAPPED;
		flag_rd = 1'b0;
		lo_rd   = '0;
		hi_rd   = '0;
		case (reg_req.addr)
			ifb_pkg::IFB_ADDR_PIXEL_REP: begin
				rd_byte = {ifb_pkg::IFB_PR_PAD, cur.avi.pixel_repetition_code}; // R1 R2
			end
			ifb_pkg::IFB_ADDR_TOP_END_LO: begin
				rd_byte = cur.avi.bar[ifb_pkg::IFB_BAR_TOP][7:0]; // R4
				lo_rd[ifb_pkg::IFB_BAR_TOP] = 1'b1;
			end
			ifb_pkg::IFB_ADDR_TOP_END_HI: begin
				rd_byte = hi_byte(cur, ifb_pkg::IFB_BAR_TOP); // R4
				hi_rd[ifb_pkg::IFB_BAR_TOP] = 1'b1;
			end
			ifb_pkg::IFB_ADDR_BOTTOM_START_LO: begin
				rd_byte = cur.avi.bar[ifb_pkg::IFB_BAR_BOTTOM][7:0]; // R6
				lo_rd[ifb_pkg::IFB_BAR_BOTTOM] = 1'b1;
			end
			ifb_pkg::IFB_ADDR_BOTTOM_START_HI: begin
				rd_byte = hi_byte(cur, ifb_pkg::IFB_BAR_BOTTOM); // R6
				hi_rd[ifb_pkg::IFB_BAR_BOTTOM] = 1'b1;
			end
			ifb_pkg::IFB_ADDR_LEFT_END_LO: begin
				rd_byte = cur.avi.bar[ifb_pkg::IFB_BAR_LEFT][7:0]; // R8
				lo_rd[ifb_pkg::IFB_BAR_LEFT] = 1'b1;
			end
			ifb_pkg::IFB_ADDR_LEFT_END_HI: begin
				rd_byte = hi_byte(cur, ifb_pkg::IFB_BAR_LEFT); // R8
				hi_rd[ifb_pkg::IFB_BAR_LEFT] = 1'b1;
			end
			ifb_pkg::IFB_ADDR_RIGHT_START_LO: begin
				rd_byte = cur.avi.bar[ifb_pkg::IFB_BAR_RIGHT][7:0]; // R10
				lo_rd[ifb_pkg::IFB_BAR_RIGHT] = 1'b1;
			end
			ifb_pkg::IFB_ADDR_RIGHT_START_HI: begin
				rd_byte = hi_byte(cur, ifb_pkg::IFB_BAR_RIGHT); // R10
				hi_rd[ifb_pkg::IFB_BAR_RIGHT] = 1'b1;
			end
			ifb_pkg::IFB_ADDR_CHANGE_FLAGS,
			ifb_pkg::IFB_ADDR_CHANGE_MIRROR: begin
				rd_byte = {ifb_pkg::IFB_FLAG_PAD, cur.flags}; // R16
				flag_rd = 1'b1;
			end
			default: begin
				rd_byte = ifb_pkg::IFB_UNMAPPED;
			end
		endcase
	end

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		next_cur = cur;

		// New bar and repetition values replace the old as a whole
		if (avi_upd) begin
			next_cur.avi = avi_in;
		end

		// Snapshot and release of the high bytes on reads only
		next_cur.rvalid = reg_req.rd;
		if (reg_req.rd) begin
			next_cur.rdata = rd_byte; // R15
			for (int b = 0; b < ifb_pkg::IFB_BARS; b++) begin
				if (lo_rd[b]) begin
					next_cur.hold_hi[b]  = cur.avi.bar[b][15:8];
					next_cur.hold_vld[b] = 1'b1;
				end else if (hi_rd[b]) begin
					next_cur.hold_vld[b] = 1'b0;
				end
			end
		end

		// Clearing read first, then the hits so a late change survives
		if (reg_req.rd && flag_rd) begin
			next_cur.flags = ifb_pkg::IFB_FLAGS_RST; // R15 R16
		end
		next_cur.flags = next_cur.flags | change_hit; // R13 R18

		// Stage one: packet waits a cycle for the stored signature
		next_cur.s1_valid   = pkt_ok;
		next_cur.s1_idx     = pkt_in.idx;
		next_cur.s1_sig     = pkt_in.sig;
		next_cur.s1_fwd     = pkt_ok && cur.s1_valid && (cur.s1_idx == pkt_in.idx);
		next_cur.s1_fwd_sig = cur.s1_sig;
		if (cur.s1_valid) begin
			next_cur.seen[cur.s1_idx] = 1'b1;
		end

		// Bar presence, one cycle behind the stored values
		next_cur.status.no_top =
			(cur.avi.bar[ifb_pkg::IFB_BAR_TOP] == ifb_pkg::IFB_BAR_NONE); // R5
		next_cur.status.no_bottom =
			(cur.avi.bar[ifb_pkg::IFB_BAR_BOTTOM] > active_lines); // R7
		next_cur.status.no_left =
			(cur.avi.bar[ifb_pkg::IFB_BAR_LEFT] == ifb_pkg::IFB_BAR_NONE); // R9
		next_cur.status.no_right =
			(cur.avi.bar[ifb_pkg::IFB_BAR_RIGHT] > max_pixels); // R11
		// Helps software skip codes it must not take as counts
		next_cur.status.pr_reserved =
			(cur.avi.pixel_repetition_code >= ifb_pkg::IFB_PR_FIRST_RSV); // R3
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cur <= '0; // R14
		end else begin
			cur <= next_cur;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	// All from flip-flops; writes never reach any of them
	assign reg_rdata    = cur.rdata; // R12
	assign reg_rvalid   = cur.rvalid;
	assign bar_status   = cur.status;
	assign change_flags = cur.flags;

endmodule // ifb_regs
`default_nettype wire

/* tb/ifb_regs_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Port checker of the bar and flag block
// ----------------------------------------
module ifb_regs_asserts (
	// Clock and reset
	input wire logic                        mclk,
	input wire logic                        nrst,
	// Register port
	input wire ifb_pkg::ifb_reg_req_s       reg_req,
	input wire logic [7:0]                  reg_rdata,
	input wire logic                        reg_rvalid,
	// Video and packet side
	input wire logic                        avi_upd,
	input wire ifb_pkg::ifb_avi_s           avi_in,
	input wire ifb_pkg::ifb_pkt_s           pkt_in,
	input wire logic [15:0]                 active_lines,
	input wire logic [15:0]                 max_pixels,
	input wire ifb_pkg::ifb_bar_status_s    bar_status,
	input wire logic [ifb_pkg::IFB_PKT_TYPES-1:0] change_flags
);
	ifb_pkg::ifb_avi_s shadow;
	logic              seen;
	logic              flag_rd;

	// Either flag address clears the one shared set
	assign flag_rd = reg_req.rd && (reg_req.addr == 8'h87 || reg_req.addr == 8'h8f);

	// Shadow of loaded info; seen masks the edge still showing reset values
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			shadow <= '0;
			seen   <= 1'b0;
		end else begin
			seen <= 1'b1;
			if (avi_upd) begin
				shadow <= avi_in;
			end
		end
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);

	// Read steps: request taken, answer one cycle on
	sequence pr_read_s;
		reg_req.rd && reg_req.addr == 8'h85;
	endsequence
	sequence flag_read_s;
		flag_rd;
	endsequence

	pr_read_a: assert property (pr_read_s |=> reg_rvalid &&
		reg_rdata == {4'h0, $past(shadow.pixel_repetition_code)}) else $error("bad repetition read");
	top_lo_a: assert property (reg_req.rd && reg_req.addr == 8'h86 |=>
		reg_rdata == $past(shadow.bar[0][7:0])) else $error("bad top bar low byte");
	flag_return_a: assert property (flag_read_s |=> reg_rvalid &&
		reg_rdata == {1'b0, $past(change_flags)}) else $error("flag read not old value");
	flag_clear_a: assert property (flag_read_s ##0 !$past(pkt_in.valid) |=>
		change_flags == 7'h00) else $error("flags not cleared");
	flag_rise_a: assert property ((change_flags & ~$past(change_flags)) != 7'h00 |->
		$past(pkt_in.valid, 2) && (change_flags & ~$past(change_flags)) ==
		(7'h01 << $past(pkt_in.idx, 2))) else $error("flag set without its packet");
	flag_sticky_a: assert property (($past(change_flags) & ~change_flags) != 7'h00 |->
		$past(flag_rd)) else $error("flag lost without a read");
	top_none_a: assert property (seen |-> bar_status.no_top ==
		($past(shadow.bar[0]) == 16'h0000)) else $error("top bar status wrong");
	bottom_none_a: assert property (seen |-> bar_status.no_bottom ==
		($past(shadow.bar[1]) > $past(active_lines))) else $error("bottom bar status wrong");
	left_none_a: assert property (seen |-> bar_status.no_left ==
		($past(shadow.bar[2]) == 16'h0000)) else $error("left bar status wrong");
	right_none_a: assert property (seen |-> bar_status.no_right ==
		($past(shadow.bar[3]) > $past(max_pixels))) else $error("right bar status wrong");

endmodule // ifb_regs_asserts

bind ifb_regs ifb_regs_asserts i_ifb_regs_asserts (
	.mclk(mclk), .nrst(nrst), .reg_req(reg_req), .reg_rdata(reg_rdata),
	.reg_rvalid(reg_rvalid), .avi_upd(avi_upd), .avi_in(avi_in), .pkt_in(pkt_in),
	.active_lines(active_lines), .max_pixels(max_pixels), .bar_status(bar_status),
	.change_flags(change_flags));
`default_nettype wire

/* tb/ifb_regs_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Bench of the bar and flag block
// ----------------------------------------
module ifb_regs_tb_top;
	logic                     mclk;
	logic                     nrst;
	logic                     reg_rvalid;
	logic                     avi_upd;
	logic [7:0]               reg_rdata;
	logic [15:0]              active_lines;
	logic [15:0]              max_pixels;
	logic [6:0]               change_flags;
	ifb_pkg::ifb_reg_req_s    reg_req;
	ifb_pkg::ifb_avi_s        avi_in;
	ifb_pkg::ifb_avi_s        v;
	ifb_pkg::ifb_pkt_s        pkt_in;
	ifb_pkg::ifb_bar_status_s bar_status;
	int                       fail_count;
	int                       n_tests;
	logic [7:0]               lo_a [4] = '{8'h86, 8'h89, 8'h8b, 8'h8d};
	logic [7:0]               hi_a [4] = '{8'h88, 8'h8a, 8'h8c, 8'h8e};

	ifb_regs i_ifb_regs (
		.mclk(mclk), .nrst(nrst), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .avi_upd(avi_upd), .avi_in(avi_in), .pkt_in(pkt_in),
		.active_lines(active_lines), .max_pixels(max_pixels), .bar_status(bar_status),
		.change_flags(change_flags));

	// 100 MHz clock
	always #5 mclk = ~mclk;

	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Answer is registered on the taking edge and checked 1 ns after it
	task rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge mclk);
		reg_req.rd   <= 1'b1;
		reg_req.addr <= a;
		@(posedge mclk);
		reg_req.rd <= 1'b0;
		#1;
		chk({7'h00, reg_rvalid}, 8'h01);
		chk(reg_rdata, exp);
	endtask

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_req.wr    <= 1'b1;
		reg_req.addr  <= a;
		reg_req.wdata <= d;
		@(posedge mclk);
		reg_req.wr <= 1'b0;
	endtask

	task pkt(input logic [2:0] i, input logic [31:0] s);
		@(posedge mclk);
		pkt_in <= '{1'b1, i, s};
		@(posedge mclk);
		pkt_in.valid <= 1'b0;
	endtask

	// Status lags the load by two edges
	task load;
		@(posedge mclk);
		avi_in  <= v;
		avi_upd <= 1'b1;
		@(posedge mclk);
		avi_upd <= 1'b0;
		repeat (2) @(posedge mclk);
		#1;
	endtask

	task finish_test;
		$display("Checks %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Watchdog, far beyond the roughly 125 cycles needed
	initial begin
		#20000;
		fail_count++;
		finish_test;
	end

	// Main sequence
	initial begin
		mclk = 1'b0;
		nrst = 1'b0;
		reg_req = '0;
		avi_upd = 1'b0;
		avi_in = '0;
		pkt_in = '0;
		active_lines = 16'h03ff;
		max_pixels = 16'h0500;
		fail_count = 0;
		n_tests = 0;
		repeat (2) @(posedge mclk);
		nrst <= 1'b1;
		rd(8'h87, 8'h00);
		rd(8'h85, 8'h00);
		chk({3'h0, bar_status}, 8'h14);
		v.pixel_repetition_code = 4'h9;
		v.bar = {16'h0500, 16'h0010, 16'h0400, 16'h1234};
		load;
		rd(8'h85, 8'h09);
		wr(8'h86, 8'hff);
		for (int i = 0; i < 4; i++) begin
			rd(lo_a[i], v.bar[i][7:0]);
			rd(hi_a[i], v.bar[i][15:8]);
		end
		rd(8'h90, 8'h00);
		chk({3'h0, bar_status}, 8'h08);
		v.pixel_repetition_code = 4'ha;
		v.bar = {16'h0501, 16'h0000, 16'h0400, 16'h0000};
		load;
		chk({3'h0, bar_status}, 8'h1f);
		// Update between low and high read must not tear the pair
		rd(8'h86, 8'h00);
		v.bar[0] = 16'h0301;
		load;
		rd(8'h88, 8'h00);
		rd(8'h88, 8'h03);
		// Each packet type owns one flag bit
		for (int i = 0; i < 7; i++) begin
			pkt(i[2:0], 32'h100 + i);
			repeat (2) @(posedge mclk);
			rd(8'h87, 8'h01 << i);
			rd(8'h8f, 8'h00);
		end
		// Unused type and repeated content set nothing
		pkt(3'h7, 32'h0);
		pkt(3'h2, 32'h102);
		repeat (2) @(posedge mclk);
		rd(8'h87, 8'h00);
		pkt(3'h1, 32'h9);
		pkt(3'h4, 32'h9);
		repeat (2) @(posedge mclk);
		rd(8'h8f, 8'h12);
		rd(8'h87, 8'h00);
		// Change landing on the clearing edge survives
		// Read raised on the taking edge, so the hit meets the clear
		@(posedge mclk);
		pkt_in <= '{1'b1, 3'h0, 32'h55};
		@(posedge mclk);
		pkt_in.valid <= 1'b0;
		reg_req.rd   <= 1'b1;
		reg_req.addr <= 8'h87;
		@(posedge mclk);
		reg_req.rd <= 1'b0;
		#1;
		chk(reg_rdata, 8'h00);
		rd(8'h87, 8'h01);
		finish_test;
	end

endmodule // ifb_regs_tb_top
`default_nettype wire
